// ---- pacc_top.sv ----
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module pacc_top #(
  parameter int PER_LOG = pacc_pkg::PER_BASE_LOG  // Log2 of shortest periodic period
) (
  input  wire logic        clock,                  // 200 MHz clock
  input  wire logic        rst,                    // Async reset, active high
  input  wire logic        psel,                   // APB select
  input  wire logic        penable,                // APB enable
  input  wire logic        pwrite,                 // APB direction
  input  wire logic [7:0]  paddr,                  // APB byte address
  input  wire logic [31:0] pwdata,                 // APB write data
  output logic      [31:0] prdata,                 // APB read data
  output logic             pready,                 // APB ready
  output logic             pslverr,                // APB error, unmapped address
  input  wire logic        accum_input_pin,        // Pulse or gate input
  output logic             accum_overflow_irq,     // Overflow request
  output logic             accum_edge_irq,         // Edge request
  output logic             periodic_irq,           // Periodic request
  output logic             fifth_output_compare,   // Output compare five enabled
  output logic             fourth_input_capture    // Input capture four enabled
);

  pacc_pkg::pacc_ctl_t ctl;
  logic [7:0]              accum_count;
  logic                    accum_overflow_flag;
  logic                    accum_edge_flag;
  logic                    periodic_irq_flag;
  logic                    accum_overflow_irq_enable;
  logic                    accum_edge_irq_enable;
  logic                    periodic_irq_enable;
  logic                    pin_meta;
  logic                    pin_sync;
  logic                    pin_prev;
  logic [pacc_pkg::GATE_W-1:0] gate_div;
  logic [pacc_pkg::PER_W-1:0]  per_div;

  logic                    setup;
  logic                    wr;
  logic                    mapped;
  logic                    wr_ctrl;
  logic                    wr_count;
  logic                    wr_mask;
  logic                    wr_flag;
  logic [31:0]             next_rdata;
  logic                    gate_tick;
  logic                    active;
  logic                    sel_edge;
  logic                    inc;
  logic                    ovf_event;
  logic                    per_event;
  logic [pacc_pkg::PER_W-1:0]  per_mask;

  assign setup = psel & ~penable;
  assign wr    = psel & penable & pready & pwrite;

  always_comb begin
    wr_ctrl  = 1'b0;
    wr_count = 1'b0;
    wr_mask  = 1'b0;
    wr_flag  = 1'b0;
    mapped   = 1'b1;
    if (paddr == pacc_pkg::CTRL_OFS) begin
      wr_ctrl = wr;
    end else if (paddr == pacc_pkg::COUNT_OFS) begin
      wr_count = wr;
    end else if (paddr == pacc_pkg::MASK_OFS) begin
      wr_mask = wr;
    end else if (paddr == pacc_pkg::FLAG_OFS) begin
      wr_flag = wr;
    end else begin
      mapped = 1'b0;
    end
  end

  // Read value is captured in the setup cycle from settled flops
  always_comb begin
    next_rdata = pacc_pkg::RD_ZERO;
    if (paddr == pacc_pkg::CTRL_OFS) begin
      next_rdata[pacc_pkg::CTL_EN_BIT]   = ctl.enable;
      next_rdata[pacc_pkg::CTL_MODE_BIT] = ctl.mode;
      next_rdata[pacc_pkg::CTL_EDGE_BIT] = ctl.edge_ctl;
      next_rdata[pacc_pkg::CTL_CCS_BIT]  = ctl.cc_sel;
      next_rdata[pacc_pkg::CTL_RATE_LSB +: 2] = ctl.rate;
    end else if (paddr == pacc_pkg::COUNT_OFS) begin
      next_rdata[7:0] = accum_count;
    end else if (paddr == pacc_pkg::MASK_OFS) begin
      next_rdata[pacc_pkg::PER_BIT]  = periodic_irq_enable;
      next_rdata[pacc_pkg::OVF_BIT]  = accum_overflow_irq_enable;
      next_rdata[pacc_pkg::EDGE_BIT] = accum_edge_irq_enable;
    end else if (paddr == pacc_pkg::FLAG_OFS) begin
      next_rdata[pacc_pkg::PER_BIT]  = periodic_irq_flag;
      next_rdata[pacc_pkg::OVF_BIT]  = accum_overflow_flag;
      next_rdata[pacc_pkg::EDGE_BIT] = accum_edge_flag;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= pacc_pkg::RD_ZERO;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? pacc_pkg::RD_ZERO : next_rdata;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctl                       <= pacc_pkg::CTL_RESET;
      accum_overflow_irq_enable <= 1'b0;
      accum_edge_irq_enable     <= 1'b0;
      periodic_irq_enable       <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctl.enable   <= pwdata[pacc_pkg::CTL_EN_BIT];
        ctl.mode     <= pwdata[pacc_pkg::CTL_MODE_BIT];
        ctl.edge_ctl <= pwdata[pacc_pkg::CTL_EDGE_BIT];
        ctl.cc_sel   <= pwdata[pacc_pkg::CTL_CCS_BIT];
        ctl.rate     <= pwdata[pacc_pkg::CTL_RATE_LSB +: 2];
      end
      if (wr_mask) begin
        periodic_irq_enable       <= pwdata[pacc_pkg::PER_BIT];
        accum_overflow_irq_enable <= pwdata[pacc_pkg::OVF_BIT];
        accum_edge_irq_enable     <= pwdata[pacc_pkg::EDGE_BIT];
      end
    end
  end

  // Pin synchroniser plus one stage for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= accum_input_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Free-running divide-by-64 gate tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_div <= '0;
    end else begin
      gate_div <= gate_div + 1'b1;
    end
  end

  assign gate_tick = (gate_div == pacc_pkg::GATE_LAST);
  assign active    = pin_sync ^ ctl.edge_ctl;
  // Falling edge at edge bit 0, rising at 1; input sync limits rate to half clock
  assign sel_edge  = ctl.edge_ctl ? (pin_sync & ~pin_prev)
                                  : (~pin_sync & pin_prev);
  assign inc       = ctl.enable & (ctl.mode ? (gate_tick & active)
                                            : sel_edge);
  assign ovf_event = inc & (accum_count == pacc_pkg::COUNT_MAX) & ~wr_count;

  // No reset: count keeps its previous value through reset; a write beats an increment
  always_ff @(posedge clock) begin
    if (wr_count) begin
      accum_count <= pwdata[7:0];
    end else if (inc) begin
      accum_count <= accum_count + pacc_pkg::COUNT_ONE;
    end
  end

  // Periodic divider, free-running since reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      per_div <= '0;
    end else begin
      per_div <= per_div + 1'b1;
    end
  end

  assign per_mask  = pacc_pkg::PER_W'((32'h1 << (PER_LOG + int'(ctl.rate))) - 1);
  assign per_event = ((per_div & per_mask) == per_mask);

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accum_overflow_flag <= 1'b0;
      accum_edge_flag     <= 1'b0;
      periodic_irq_flag   <= 1'b0;
    end else begin
      if (ovf_event) begin
        accum_overflow_flag <= 1'b1;
      end else if (wr_flag & pwdata[pacc_pkg::OVF_BIT]) begin
        accum_overflow_flag <= 1'b0;
      end
      if (ctl.enable & sel_edge) begin
        accum_edge_flag <= 1'b1;
      end else if (wr_flag & pwdata[pacc_pkg::EDGE_BIT]) begin
        accum_edge_flag <= 1'b0;
      end
      if (per_event) begin
        periodic_irq_flag <= 1'b1;
      end else if (wr_flag & pwdata[pacc_pkg::PER_BIT]) begin
        periodic_irq_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accum_overflow_irq   <= 1'b0;
      accum_edge_irq       <= 1'b0;
      periodic_irq         <= 1'b0;
      fifth_output_compare <= 1'b0;
      fourth_input_capture <= 1'b0;
    end else begin
      accum_overflow_irq   <= accum_overflow_flag & accum_overflow_irq_enable;
      accum_edge_irq       <= accum_edge_flag & accum_edge_irq_enable;
      periodic_irq         <= periodic_irq_flag & periodic_irq_enable;
      fifth_output_compare <= ~ctl.cc_sel;
      fourth_input_capture <= ctl.cc_sel;
    end
  end

  ovf_set_a: assert property (@(posedge clock) disable iff (rst)
    ovf_event |=> accum_overflow_flag && accum_count == 8'h00)
    else $error("overflow flag not set on rollover");

  ovf_clear_a: assert property (@(posedge clock) disable iff (rst)
    (wr_flag && pwdata[pacc_pkg::OVF_BIT] && !ovf_event) |=> !accum_overflow_flag)
    else $error("overflow flag not cleared by write of one");

  ovf_keep_a: assert property (@(posedge clock) disable iff (rst)
    (accum_overflow_flag && !(wr_flag && pwdata[pacc_pkg::OVF_BIT])) |=> accum_overflow_flag)
    else $error("overflow flag lost without clear");

  edge_irq_a: assert property (@(posedge clock) disable iff (rst)
    (accum_edge_flag && accum_edge_irq_enable) |=> accum_edge_irq)
    else $error("edge request missing");

  ovf_irq_a: assert property (@(posedge clock) disable iff (rst)
    accum_overflow_irq |-> $past(accum_overflow_flag) && $past(accum_overflow_irq_enable))
    else $error("overflow request without flag");

  edge_flag_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.enable && $fell(pin_sync) && !ctl.edge_ctl) |=> accum_edge_flag)
    else $error("falling edge not flagged");

  disable_hold_a: assert property (@(posedge clock) disable iff (rst)
    (!ctl.enable && !wr_count) |=> $stable(accum_count))
    else $error("count moved while disabled");

  gated_count_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.enable && ctl.mode && !wr_count && !gate_tick) |=> $stable(accum_count))
    else $error("gated count moved between ticks");

  count_write_a: assert property (@(posedge clock) disable iff (rst)
    wr_count |=> accum_count == $past(pwdata[7:0]))
    else $error("count write lost");

  period_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.rate == 2'h0 && per_div == '0) |-> !per_event ##1 !per_event)
    else $error("periodic timeout too early");

  cc_sel_a: assert property (@(posedge clock) disable iff (rst)
    !(fifth_output_compare && fourth_input_capture))
    else $error("capture and compare both enabled");

  apb_ready_a: assert property (@(posedge clock) disable iff (rst)
    setup |=> pready ##1 !pready)
    else $error("ready not a single access cycle");

  localparam int GATE_SPAN = pacc_pkg::GATE_DIV;

  ovf_irq_on_a: assert property (@(posedge clock) disable iff (rst)
    (accum_overflow_flag && accum_overflow_irq_enable) |=> accum_overflow_irq)
    else $error("overflow request missing");

  edge_irq_off_a: assert property (@(posedge clock) disable iff (rst)
    accum_edge_irq |-> $past(accum_edge_flag) && $past(accum_edge_irq_enable))
    else $error("edge request without flag");

  rise_flag_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.enable && $rose(pin_sync) && ctl.edge_ctl) |=> accum_edge_flag)
    else $error("rising edge not flagged");

  edge_clear_a: assert property (@(posedge clock) disable iff (rst)
    (wr_flag && pwdata[pacc_pkg::EDGE_BIT] && $stable(pin_sync)) |=> !accum_edge_flag)
    else $error("edge flag not cleared by write of one");

  idle_edge_a: assert property (@(posedge clock) disable iff (rst)
    (!ctl.enable && !accum_edge_flag) |=> !accum_edge_flag)
    else $error("edge flag set while disabled");

  fall_count_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.enable && !ctl.mode && !ctl.edge_ctl && $fell(pin_sync) && !wr_count)
      |=> accum_count == $past(accum_count) + pacc_pkg::COUNT_ONE)
    else $error("falling edge not counted");

  rise_count_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.enable && !ctl.mode && ctl.edge_ctl && $rose(pin_sync) && !wr_count)
      |=> accum_count == $past(accum_count) + pacc_pkg::COUNT_ONE)
    else $error("rising edge not counted");

  event_hold_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.enable && !ctl.mode && $stable(pin_sync) && !wr_count) |=> $stable(accum_count))
    else $error("event count moved without an edge");

  gated_tick_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.enable && ctl.mode && gate_tick && pin_sync != ctl.edge_ctl && !wr_count)
      |=> accum_count == $past(accum_count) + pacc_pkg::COUNT_ONE)
    else $error("gated tick not counted");

  gated_block_a: assert property (@(posedge clock) disable iff (rst)
    (ctl.enable && ctl.mode && pin_sync == ctl.edge_ctl && !wr_count) |=> $stable(accum_count))
    else $error("gated count moved while inhibited");

  per_flag_a: assert property (@(posedge clock) disable iff (rst)
    per_event |=> periodic_irq_flag)
    else $error("periodic timeout not flagged");

  tick_span_a: assert property (@(posedge clock) disable iff (rst)
    gate_tick |-> ##GATE_SPAN gate_tick)
    else $error("gate tick spacing wrong");

  cc_follow_a: assert property (@(posedge clock) disable iff (rst)
    fourth_input_capture == $past(ctl.cc_sel))
    else $error("capture select not followed");

endmodule

// ---- pacc_pkg.sv ----
package pacc_pkg;

  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS  = 8'h08;
  localparam logic [7:0] FLAG_OFS  = 8'h0C;

  localparam int CTL_EN_BIT   = 6;
  localparam int CTL_MODE_BIT = 5;
  localparam int CTL_EDGE_BIT = 4;
  localparam int CTL_CCS_BIT  = 2;
  localparam int CTL_RATE_LSB = 0;

  localparam int PER_BIT  = 6;
  localparam int OVF_BIT  = 5;
  localparam int EDGE_BIT = 4;

  localparam int          GATE_DIV     = 64;
  localparam int          GATE_W       = 6;
  localparam logic [5:0]  GATE_LAST    = 6'(GATE_DIV - 1);
  localparam int          PER_W        = 16;
  localparam int          PER_BASE_LOG = 13;

  localparam logic [7:0]  COUNT_MAX    = 8'hFF;
  localparam logic [7:0]  COUNT_ONE    = 8'h01;
  localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

  typedef struct packed {
    logic       enable;
    logic       mode;
    logic       edge_ctl;
    logic       cc_sel;
    logic [1:0] rate;
  } pacc_ctl_t;

  localparam pacc_ctl_t CTL_RESET = '{enable: 1'b0, mode: 1'b0, edge_ctl: 1'b0,
                                      cc_sel: 1'b0, rate: 2'h0};

endpackage

// ---- pacc_pulse_src.sv ----
`timescale 1ns/1ps
module pacc_pulse_src (
  input  wire logic        clock,      // Bench clock
  input  wire logic        rst,        // Async reset, active high
  input  wire logic        start,      // Begin a burst
  input  wire logic [7:0]  pulses,     // Pulses in the burst, nonzero
  input  wire logic [15:0] hold,       // Cycles per level
  input  wire logic        idle_level, // Level between bursts
  output logic             pin,        // Accumulator input
  output logic             busy        // Burst running
);
  logic [8:0]  halves;
  logic [15:0] left;
  logic [15:0] hold_eff;
  // No level shorter than two clocks
  assign hold_eff = (hold < 16'h0002) ? 16'h0002 : hold;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy   <= 1'b0;
      halves <= 9'h000;
      left   <= 16'h0000;
      pin    <= idle_level;
    end else if (start && !busy) begin
      busy   <= 1'b1;
      halves <= {pulses, 1'b0};
      left   <= hold_eff;
      pin    <= ~idle_level;
    end else if (busy && left > 16'h0001) begin
      left <= left - 16'h0001;
    end else if (busy && halves > 9'h001) begin
      halves <= halves - 9'h001;
      left   <= hold_eff;
      pin    <= ~pin;
    end else begin
      busy <= 1'b0;
      pin  <= idle_level;
    end
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam int          PL  = 4;
  localparam logic [31:0] EN  = 32'h1 << pacc_pkg::CTL_EN_BIT;
  localparam logic [31:0] MD  = 32'h1 << pacc_pkg::CTL_MODE_BIT;
  localparam logic [31:0] ED  = 32'h1 << pacc_pkg::CTL_EDGE_BIT;
  localparam logic [31:0] CC  = 32'h1 << pacc_pkg::CTL_CCS_BIT;
  localparam logic [31:0] PE  = 32'h1 << pacc_pkg::PER_BIT;
  localparam logic [31:0] OV  = 32'h1 << pacc_pkg::OVF_BIT;
  localparam logic [31:0] EG  = 32'h1 << pacc_pkg::EDGE_BIT;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, pin;
  logic        ovf_irq, edge_irq, per_irq, foc, fic, src_start, src_idle, src_busy;
  logic [7:0]  paddr, src_pulses;
  logic [15:0] src_hold;
  logic [31:0] pwdata, prdata, r;
  int          bad_count, compares, cyc, t0, t1;
  pacc_top #(.PER_LOG(PL)) dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .accum_input_pin(pin), .accum_overflow_irq(ovf_irq),
    .accum_edge_irq(edge_irq), .periodic_irq(per_irq), .fifth_output_compare(foc),
    .fourth_input_capture(fic));
  pacc_pulse_src src_u (.clock(clock), .rst(rst), .start(src_start), .pulses(src_pulses),
    .hold(src_hold), .idle_level(src_idle), .pin(pin), .busy(src_busy));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  task automatic final_report();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic burst(input logic [7:0] n, input logic [15:0] h);
    @(posedge clock);
    src_pulses <= n;
    src_hold   <= h;
    src_start  <= 1'b1;
    @(posedge clock);
    src_start <= 1'b0;
    @(posedge clock);
    while (src_busy === 1'b1) @(posedge clock);
    repeat (5) @(posedge clock);
  endtask
  task automatic catch_rise(output int t);
    // Let a just-cleared request drop before looking for the next rise
    repeat (2) @(posedge clock);
    while (per_irq !== 1'b1) @(posedge clock);
    t = cyc;
  endtask
  initial begin
    logic e;
    {psel, penable, pwrite, paddr, pwdata, src_start, src_pulses, src_hold} = '0;
    {bad_count, compares, cyc} = '0;
    src_idle = 1'b1;
    rst = 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(pacc_pkg::CTRL_OFS, r);
    cmp32(r, 32'h0);
    wr(pacc_pkg::COUNT_OFS, 32'h5A);
    @(posedge clock) rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    rd(pacc_pkg::COUNT_OFS, r);
    cmp32(r, 32'h5A);
    cmp1(foc, 1'b1);
    wr(pacc_pkg::CTRL_OFS, CC);
    rd(pacc_pkg::CTRL_OFS, r);
    cmp32(r, CC);
    cmp1(fic & ~foc, 1'b1);
    apb(1'b0, 8'h10, 32'h0, r, e);
    cmp1(e, 1'b1);
    cmp32(r, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(pacc_pkg::CTRL_OFS, 32'h0);
      src_idle <= ~k[0];
      repeat (4) @(posedge clock);
      wr(pacc_pkg::COUNT_OFS, 32'h0);
      wr(pacc_pkg::FLAG_OFS, OV | EG);
      burst(8'd3, 16'd2);
      rd(pacc_pkg::COUNT_OFS, r);
      cmp32(r, 32'h0);
      rd(pacc_pkg::FLAG_OFS, r);
      cmp32(r & EG, 32'h0);
      wr(pacc_pkg::CTRL_OFS, EN | (k[0] ? ED : 32'h0));
      burst(8'd5, 16'd2);
      rd(pacc_pkg::COUNT_OFS, r);
      cmp32(r, 32'h5);
      rd(pacc_pkg::FLAG_OFS, r);
      cmp32(r & EG, EG);
    end
    wr(pacc_pkg::MASK_OFS, 32'h0);
    wr(pacc_pkg::FLAG_OFS, OV | EG);
    wr(pacc_pkg::COUNT_OFS, 32'hFF);
    burst(8'd1, 16'd3);
    rd(pacc_pkg::COUNT_OFS, r);
    cmp32(r, 32'h0);
    rd(pacc_pkg::FLAG_OFS, r);
    cmp32(r & (OV | EG), OV | EG);
    cmp1(ovf_irq | edge_irq, 1'b0);
    wr(pacc_pkg::MASK_OFS, OV | EG);
    repeat (2) @(posedge clock);
    cmp1(ovf_irq & edge_irq, 1'b1);
    wr(pacc_pkg::FLAG_OFS, 32'h0);
    rd(pacc_pkg::FLAG_OFS, r);
    cmp32(r & (OV | EG), OV | EG);
    wr(pacc_pkg::FLAG_OFS, OV);
    rd(pacc_pkg::FLAG_OFS, r);
    cmp32(r & (OV | EG), EG);
    cmp1(ovf_irq, 1'b0);
    wr(pacc_pkg::FLAG_OFS, EG);
    rd(pacc_pkg::FLAG_OFS, r);
    cmp32(r & (OV | EG), 32'h0);
    cmp1(edge_irq, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(pacc_pkg::CTRL_OFS, 32'h0);
      src_idle <= k[0];
      repeat (4) @(posedge clock);
      wr(pacc_pkg::COUNT_OFS, 32'h0);
      wr(pacc_pkg::CTRL_OFS, EN | MD | (k[0] ? ED : 32'h0));
      burst(8'd1, 16'd256);
      rd(pacc_pkg::COUNT_OFS, r);
      cmp32(r, 32'h4);
    end
    wr(pacc_pkg::MASK_OFS, PE);
    for (int k = 0; k < 4; k++) begin
      wr(pacc_pkg::CTRL_OFS, 32'(k));
      catch_rise(t0);
      wr(pacc_pkg::FLAG_OFS, PE);
      catch_rise(t0);
      wr(pacc_pkg::FLAG_OFS, PE);
      catch_rise(t1);
      cmp32(32'(t1 - t0), 32'h1 << (PL + k));
    end
    final_report();
  end
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
endmodule
